// [host_mem.sv]
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Host memory holding descriptors and buffers
// ****************************************
module host_mem (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] words [0:255];
  logic [3:0] wait_r;
  logic ack_r;
  logic [31:0] rdata_r;

  // Outputs straight from the answer registers
  assign mem_ack = ack_r;
  assign mem_rdata = rdata_r;

  // Empty memory and scrambled read data at start
  initial begin
    for (int i = 0; i < 256; i++) begin
      words[i] = 32'h0000_0000;
    end
    rdata_r = 32'h5A5A_A5A5;
  end

  // Answer after lat idle cycles; data lines toggle when not answering
  always @(posedge core_clk) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      wait_r <= 4'h0;
    end else if (mem_req && !ack_r) begin
      if (wait_r >= lat) begin
        ack_r <= 1'b1;
        wait_r <= 4'h0;
        rdata_r <= words[mem_addr[9:2]];
        if (mem_we) begin
          words[mem_addr[9:2]] <= mem_wdata;
        end
      end else begin
        wait_r <= wait_r + 4'h1;
        rdata_r <= ~rdata_r;
      end
    end else begin
      ack_r <= 1'b0;
      rdata_r <= ~rdata_r;
    end
  end
endmodule // host_mem
`default_nettype wire

// [rx_desc_pkg.sv]
`default_nettype none
package rx_desc_pkg;
  // ****************************************
  // Descriptor layout
  // ****************************************
  localparam int WORD_BYTES = 4;
  localparam int DESC_STRIDE = 16;
  localparam logic [1:0] W_STATUS = 2'h0;
  localparam logic [1:0] W_CONTROL = 2'h1;
  localparam logic [1:0] W_BUF_ONE = 2'h2;
  localparam logic [1:0] W_BUF_TWO = 2'h3;
  // Status word fields
  localparam int ST_OWN = 31;
  localparam int ST_LEN_HI = 30;
  localparam int ST_LEN_LO = 16;
  localparam int ST_ERR_SUM = 15;
  localparam int ST_FIT_FAIL = 14;
  localparam int ST_SRC_HI = 13;
  localparam int ST_SRC_LO = 12;
  localparam int ST_RUNT = 11;
  localparam int ST_MCAST = 10;
  localparam int ST_START = 9;
  localparam int ST_END = 8;
  localparam int ST_OVERSIZE = 7;
  localparam int ST_LATE_COLL = 6;
  localparam int ST_KIND = 5;
  localparam int ST_WDOG = 4;
  localparam int ST_DRIBBLE = 2;
  localparam int ST_CRC = 1;
  localparam int ST_OVERFLOW = 0;
  // Control word fields
  localparam int CT_RING_END = 25;
  localparam int CT_CHAIN = 24;
  localparam int CT_SZ2_HI = 21;
  localparam int CT_SZ2_LO = 11;
  localparam int CT_SZ1_HI = 10;
  localparam int CT_SZ1_LO = 0;
  // ****************************************
  // Frame limits and timing
  // ****************************************
  localparam logic [14:0] RUNT_LIMIT = 15'h0040;
  localparam logic [14:0] OVERSIZE_LIMIT = 15'h05EE;
  localparam int CLK_PERIOD_NS = 10;
  localparam int POLL_GAP_NS = 1000;
  localparam int POLL_CYCLES =
    (POLL_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Reset values
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [10:0] SIZE_RST = 11'h000;
endpackage
`default_nettype wire

// [rx_descriptor_writeback.sv]
`timescale 1ns/1ns
`default_nettype none
module rx_descriptor_writeback #(
  parameter int POLL_CYCLES = rx_desc_pkg::POLL_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic [31:0] list_base,
  output logic mem_req_r,
  output logic mem_we_r,
  output logic [31:0] mem_addr_r,
  output logic [31:0] mem_wdata_r,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic rx_valid,
  output logic rx_ready_r,
  input wire logic [31:0] rx_data,
  input wire logic rx_last,
  input wire logic [14:0] rx_frame_length,
  input wire logic rx_fifo_overflow,
  input wire logic rx_crc_fail,
  input wire logic rx_late_coll,
  input wire logic rx_watchdog,
  input wire logic rx_dribble,
  input wire logic rx_multicast,
  input wire logic rx_frame_kind,
  input wire logic [1:0] rx_source_kind,
  output logic host_owned_r,
  output logic frame_done_r,
  output logic [31:0] desc_addr_r
);
  // ****************************************
  // Declarations
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_POLL, ST_WAIT, ST_WRITE, ST_STATUS, ST_NEXT
  } state_e;

  state_e state_r;
  logic [1:0] word_idx_r;
  logic [31:0] base_r;
  logic [31:0] ctl_r;
  logic [31:0] buf_one_r;
  logic [31:0] buf_two_r;
  logic [31:0] buf_ptr_r;
  logic [10:0] buf_left_r;
  logic buf_sel_r;
  logic trunc_r;
  logic own_seen_r;
  logic [31:0] data_r;
  logic [15:0] poll_cnt_r;
  logic [14:0] len_r;
  logic [9:0] flags_r;
  logic [31:0] status_word;
  logic [31:0] next_addr;
  logic buf_two_usable;
  logic take;
  logic need_switch;
  logic [10:0] size_two;

  // Poll count must fit the counter and span at least two cycles
  if (POLL_CYCLES < 2 || POLL_CYCLES > 65535) begin : g_poll_check
    $error("POLL_CYCLES out of range");
  end

  // ****************************************
  // Helpers
  // ****************************************
  // Address of one descriptor word
  function automatic logic [31:0] word_addr(input logic [31:0] base,
                                             input logic [1:0] idx);
    word_addr = base + {28'h0000000, idx, 2'h0};
  endfunction

  assign size_two = ctl_r[rx_desc_pkg::CT_SZ2_HI:rx_desc_pkg::CT_SZ2_LO];
  assign take = rx_valid & rx_ready_r;
  // Move on to buffer two once buffer one is used up
  assign need_switch = (buf_left_r == rx_desc_pkg::SIZE_RST) & ~buf_sel_r &
    buf_two_usable & (size_two != rx_desc_pkg::SIZE_RST);

  rx_status_pack u_pack (
    .frame_length(len_r),
    .fifo_overflow(flags_r[0]),
    .crc_fail(flags_r[1]),
    .late_coll(flags_r[2]),
    .watchdog(flags_r[3]),
    .dribble_flag(flags_r[4]),
    .multicast_flag(flags_r[5]),
    .frame_kind(flags_r[6]),
    .source_kind(flags_r[8:7]),
    .buffer_fit_failure(trunc_r),
    .rx_status_word(status_word)
  );

  rx_link_step u_link (
    .desc_addr(desc_addr_r),
    .list_base(base_r),
    .rx_control_word(ctl_r),
    .rx_buffer_two_pointer(buf_two_r),
    .next_addr(next_addr),
    .buf_two_usable(buf_two_usable)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  // Descriptor fetch, fill, writeback and advance
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      word_idx_r <= 2'h0;
      base_r <= rx_desc_pkg::ADDR_RST;
      desc_addr_r <= rx_desc_pkg::ADDR_RST;
      ctl_r <= rx_desc_pkg::ADDR_RST;
      buf_one_r <= rx_desc_pkg::ADDR_RST;
      buf_two_r <= rx_desc_pkg::ADDR_RST;
      buf_ptr_r <= rx_desc_pkg::ADDR_RST;
      buf_left_r <= rx_desc_pkg::SIZE_RST;
      buf_sel_r <= 1'b0;
      own_seen_r <= 1'b0;
      poll_cnt_r <= 16'h0000;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= rx_desc_pkg::ADDR_RST;
      mem_wdata_r <= 32'h0000_0000;
      rx_ready_r <= 1'b0;
      frame_done_r <= 1'b0;
      host_owned_r <= 1'b0;
    end else begin
      frame_done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (enable) begin
            base_r <= list_base;
            desc_addr_r <= list_base;
            word_idx_r <= rx_desc_pkg::W_STATUS;
            state_r <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (!mem_req_r) begin
            mem_req_r <= 1'b1;
            mem_we_r <= 1'b0;
            mem_addr_r <= word_addr(desc_addr_r, word_idx_r);
          end else if (mem_ack) begin
            mem_req_r <= 1'b0;
            word_idx_r <= word_idx_r + 2'h1;
            case (word_idx_r)
              rx_desc_pkg::W_STATUS: begin
                own_seen_r <= mem_rdata[rx_desc_pkg::ST_OWN];
                if (!mem_rdata[rx_desc_pkg::ST_OWN]) begin
                  host_owned_r <= 1'b1;
                  poll_cnt_r <= 16'(POLL_CYCLES);
                  state_r <= ST_POLL;
                end
              end
              rx_desc_pkg::W_CONTROL: ctl_r <= mem_rdata;
              rx_desc_pkg::W_BUF_ONE: buf_one_r <= mem_rdata;
              default: begin
                buf_two_r <= mem_rdata;
                host_owned_r <= 1'b0;
                buf_sel_r <= 1'b0;
                buf_ptr_r <= buf_one_r;
                buf_left_r <= ctl_r[rx_desc_pkg::CT_SZ1_HI:
                                    rx_desc_pkg::CT_SZ1_LO];
                state_r <= ST_WAIT;
              end
            endcase
          end
        end
        ST_POLL: begin
          if (poll_cnt_r <= 16'h0001) begin
            word_idx_r <= rx_desc_pkg::W_STATUS;
            state_r <= enable ? ST_FETCH : ST_IDLE;
          end else begin
            poll_cnt_r <= poll_cnt_r - 16'h0001;
          end
        end
        ST_WAIT: begin
          if (take) begin
            if (buf_left_r != rx_desc_pkg::SIZE_RST) begin
              rx_ready_r <= 1'b0;
              mem_req_r <= 1'b1;
              mem_we_r <= 1'b1;
              mem_addr_r <= buf_ptr_r;
              mem_wdata_r <= rx_data;
              state_r <= ST_WRITE;
            end else if (rx_last) begin
              rx_ready_r <= 1'b0;
              state_r <= ST_STATUS;
            end
          end else if (!rx_ready_r) begin
            if (need_switch) begin
              buf_sel_r <= 1'b1;
              buf_ptr_r <= buf_two_r;
              buf_left_r <= size_two;
            end else begin
              rx_ready_r <= 1'b1;
            end
          end
        end
        ST_WRITE: begin
          if (mem_ack) begin
            mem_req_r <= 1'b0;
            mem_we_r <= 1'b0;
            buf_ptr_r <= buf_ptr_r + 32'(rx_desc_pkg::WORD_BYTES);
            buf_left_r <= (buf_left_r < 11'h004) ? rx_desc_pkg::SIZE_RST :
              buf_left_r - 11'h004;
            state_r <= flags_r[9] ? ST_STATUS : ST_WAIT;
          end
        end
        ST_STATUS: begin
          if (!mem_req_r) begin
            mem_req_r <= own_seen_r;
            mem_we_r <= own_seen_r;
            mem_addr_r <= desc_addr_r;
            mem_wdata_r <= status_word;
          end else if (mem_ack) begin
            mem_req_r <= 1'b0;
            mem_we_r <= 1'b0;
            state_r <= ST_NEXT;
          end
        end
        default: begin
          desc_addr_r <= next_addr;
          own_seen_r <= 1'b0;
          frame_done_r <= 1'b1;
          word_idx_r <= rx_desc_pkg::W_STATUS;
          state_r <= enable ? ST_FETCH : ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Frame status capture
  // ****************************************
  // Latch per-frame flags with the last word; flags_r[9] marks the end
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      len_r <= 15'h0000;
      flags_r <= 10'h000;
      trunc_r <= 1'b0;
    end else if (state_r == ST_NEXT) begin
      flags_r <= 10'h000;
      trunc_r <= 1'b0;
    end else if (state_r == ST_WAIT && take) begin
      if (buf_left_r == rx_desc_pkg::SIZE_RST) begin
        trunc_r <= 1'b1;
      end
      if (rx_last) begin
        len_r <= rx_frame_length;
        flags_r <= {1'b1, rx_source_kind, rx_frame_kind,
                    rx_multicast, rx_dribble, rx_watchdog,
                    rx_late_coll, rx_crc_fail, rx_fifo_overflow};
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic status_wr;
  assign status_wr = mem_req_r & mem_we_r & (state_r == ST_STATUS);

  sequence fetch_done_s;
    state_r == ST_FETCH && mem_req_r && mem_ack &&
      word_idx_r == rx_desc_pkg::W_BUF_TWO;
  endsequence

  sequence not_owned_s;
    state_r == ST_FETCH && mem_req_r && mem_ack &&
      word_idx_r == rx_desc_pkg::W_STATUS && !mem_rdata[31];
  endsequence

  owned_write_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    status_wr |-> own_seen_r) else $error("status write without ownership");

  own_cleared_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    status_wr |-> !mem_wdata_r[31]) else $error("own bit left set");

  error_or_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    status_wr |-> mem_wdata_r[15] == (mem_wdata_r[0] | mem_wdata_r[1] |
      mem_wdata_r[6] | mem_wdata_r[7] | mem_wdata_r[11] | mem_wdata_r[14]))
    else $error("error summary mismatch");

  length_flags_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    status_wr |-> mem_wdata_r[30:16] == len_r &&
      mem_wdata_r[11] == (len_r < rx_desc_pkg::RUNT_LIMIT) &&
      mem_wdata_r[7] == (len_r > rx_desc_pkg::OVERSIZE_LIMIT))
    else $error("length or size flags wrong");

  poll_hold_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    not_owned_s |=> (state_r == ST_POLL && !mem_req_r)[*2])
    else $error("descriptor used while host owns it");

  ring_end_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    state_r == ST_NEXT && ctl_r[25] |=> desc_addr_r == base_r)
    else $error("ring end did not return to base");

  chain_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    state_r == ST_NEXT && !ctl_r[25] && ctl_r[24] |=>
      desc_addr_r == $past(buf_two_r)) else $error("chain link not followed");

  fill_start_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    fetch_done_s |=> state_r == ST_WAIT && buf_ptr_r == buf_one_r &&
      buf_left_r == ctl_r[10:0]) else $error("buffer one not loaded");

  trunc_flag_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    state_r == ST_WAIT && take && buf_left_r == 11'h000 |=> trunc_r)
    else $error("truncation not flagged");

  done_pulse_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    state_r == ST_STATUS && mem_req_r && mem_ack |-> ##2 frame_done_r ##1
      !frame_done_r) else $error("frame done pulse wrong");
endmodule // rx_descriptor_writeback
`default_nettype wire

// [rx_link_step.sv]
`timescale 1ns/1ns
`default_nettype none
module rx_link_step (
  input wire logic [31:0] desc_addr,
  input wire logic [31:0] list_base,
  input wire logic [31:0] rx_control_word,
  input wire logic [31:0] rx_buffer_two_pointer,
  output logic [31:0] next_addr,
  output logic buf_two_usable
);
  logic ring_end;
  logic chain_next;

  assign ring_end = rx_control_word[rx_desc_pkg::CT_RING_END];
  assign chain_next = rx_control_word[rx_desc_pkg::CT_CHAIN];

  // Ring end wins over chaining; word four is a buffer unless chained without ring end
  always_comb begin
    if (ring_end) begin
      next_addr = list_base;
    end else if (chain_next) begin
      next_addr = rx_buffer_two_pointer;
    end else begin
      next_addr = desc_addr + 32'(rx_desc_pkg::DESC_STRIDE);
    end
    buf_two_usable = ring_end | ~chain_next;
  end
endmodule // rx_link_step
`default_nettype wire

// [rx_status_pack.sv]
`timescale 1ns/1ns
`default_nettype none
module rx_status_pack (
  input wire logic [14:0] frame_length,
  input wire logic fifo_overflow,
  input wire logic crc_fail,
  input wire logic late_coll,
  input wire logic watchdog,
  input wire logic dribble_flag,
  input wire logic multicast_flag,
  input wire logic frame_kind,
  input wire logic [1:0] source_kind,
  input wire logic buffer_fit_failure,
  output logic [31:0] rx_status_word
);
  logic runt_flag;
  logic oversize_flag;
  logic error_summary;

  // Length based flags
  assign runt_flag = frame_length < rx_desc_pkg::RUNT_LIMIT;
  assign oversize_flag = frame_length > rx_desc_pkg::OVERSIZE_LIMIT;
  // Error summary over the error bits
  assign error_summary = fifo_overflow | crc_fail | late_coll |
    oversize_flag | runt_flag | buffer_fit_failure;

  // Word assembly, ownership handed back, one descriptor per frame
  always_comb begin
    rx_status_word = 32'h0000_0000;
    rx_status_word[rx_desc_pkg::ST_OWN] = 1'b0;
    rx_status_word[rx_desc_pkg::ST_LEN_HI:rx_desc_pkg::ST_LEN_LO] =
      frame_length;
    rx_status_word[rx_desc_pkg::ST_ERR_SUM] = error_summary;
    rx_status_word[rx_desc_pkg::ST_FIT_FAIL] = buffer_fit_failure;
    rx_status_word[rx_desc_pkg::ST_SRC_HI:rx_desc_pkg::ST_SRC_LO] =
      source_kind;
    rx_status_word[rx_desc_pkg::ST_RUNT] = runt_flag;
    rx_status_word[rx_desc_pkg::ST_MCAST] = multicast_flag;
    rx_status_word[rx_desc_pkg::ST_START] = 1'b1;
    rx_status_word[rx_desc_pkg::ST_END] = 1'b1;
    rx_status_word[rx_desc_pkg::ST_OVERSIZE] = oversize_flag;
    rx_status_word[rx_desc_pkg::ST_LATE_COLL] = late_coll;
    rx_status_word[rx_desc_pkg::ST_KIND] = frame_kind;
    rx_status_word[rx_desc_pkg::ST_WDOG] = watchdog;
    rx_status_word[rx_desc_pkg::ST_DRIBBLE] = dribble_flag;
    rx_status_word[rx_desc_pkg::ST_CRC] = crc_fail;
    rx_status_word[rx_desc_pkg::ST_OVERFLOW] = fifo_overflow;
  end
endmodule // rx_status_pack
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ****************************************
  // Signals
  // ****************************************
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic enable = 1'b0;
  logic [31:0] list_base = 32'h0000_0040;
  logic mem_req, mem_we, mem_ack, rx_ready, host_owned, frame_done;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, desc_addr;
  logic rx_valid = 1'b0;
  logic rx_last = 1'b0;
  logic [31:0] rx_data = 32'h0000_0000;
  logic [14:0] rx_frame_length = 15'h0000;
  logic ovf = 1'b0, crc = 1'b0, late = 1'b0, wdog = 1'b0;
  logic drib = 1'b0, mcast = 1'b0, kind = 1'b0;
  logic [1:0] src = 2'h0;
  logic [3:0] lat = 4'h0;
  logic [14:0] lens [4] = '{15'h003F, 15'h0040, 15'h05EE, 15'h05EF};
  int err_total = 0;
  int checks_done = 0;

  // Clock
  always #5 core_clk = ~core_clk;

  rx_descriptor_writeback #(.POLL_CYCLES(2)) dut (
    .core_clk(core_clk), .nrst(nrst), .enable(enable),
    .list_base(list_base), .mem_req_r(mem_req), .mem_we_r(mem_we),
    .mem_addr_r(mem_addr), .mem_wdata_r(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .rx_valid(rx_valid), .rx_ready_r(rx_ready),
    .rx_data(rx_data), .rx_last(rx_last),
    .rx_frame_length(rx_frame_length), .rx_fifo_overflow(ovf),
    .rx_crc_fail(crc), .rx_late_coll(late), .rx_watchdog(wdog),
    .rx_dribble(drib), .rx_multicast(mcast), .rx_frame_kind(kind),
    .rx_source_kind(src), .host_owned_r(host_owned),
    .frame_done_r(frame_done), .desc_addr_r(desc_addr)
  );

  host_mem mem (
    .core_clk(core_clk), .nrst(nrst), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lat(lat),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Host side: word-aligned descriptor with pointers in words 2 and 3
  task automatic mk_desc(input int a, input logic own, input logic re,
      input logic ch, input logic [10:0] s1, input logic [10:0] s2,
      input logic [31:0] b1, input logic [31:0] b2);
    mem.words[a / 4] = {own, 31'h0000_1234};
    mem.words[a / 4 + 1] = {6'h00, re, ch, 2'h0, s2, s1};
    mem.words[a / 4 + 2] = b1;
    mem.words[a / 4 + 3] = b2;
  endtask

  task automatic put_word(input logic [31:0] d, input logic l);
    int n;
    n = 0;
    @(posedge core_clk);
    #1;
    rx_valid = 1'b1;
    rx_data = d;
    rx_last = l;
    @(posedge core_clk);
    while (rx_ready !== 1'b1 && n < 500) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 500) err_total++;
    #1;
    rx_valid = 1'b0;
    rx_last = 1'b0;
  endtask

  task automatic wait_own(input logic v);
    int n;
    n = 0;
    while (host_owned !== v && n < 300) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk({31'h0, host_owned}, {31'h0, v});
  endtask

  task automatic wait_addr(input logic [31:0] a);
    int n;
    n = 0;
    while (desc_addr !== a && n < 300) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(desc_addr, a);
  endtask

  // Send a frame, then compare the written status word
  task automatic run_frame(input int a, input int n, input logic [31:0] d,
      input logic [14:0] len, input logic fit);
    int k;
    logic runt, over;
    logic [31:0] st, seen;
    rx_frame_length = len;
    for (k = 0; k < n; k++) put_word(d + k, k == n - 1);
    k = 0;
    while (frame_done !== 1'b1 && k < 300) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (k >= 300) err_total++;
    runt = len < 15'h0040;
    over = len > 15'h05EE;
    st = {1'b0, len, ovf | crc | late | over | runt | fit, fit, src, runt,
          mcast, 2'b11, over, late, kind, wdog, 1'b0, drib, crc, ovf};
    seen = mem.words[a / 4];
    chk({16'h0, seen[31:16]}, {16'h0, st[31:16]});
    chk({28'h0, seen[15:12]}, {28'h0, st[15:12]});
    chk({28'h0, seen[11:8]}, {28'h0, st[11:8]});
    chk({28'h0, seen[7:4]}, {28'h0, st[7:4]});
    chk({28'h0, seen[3:0]}, {28'h0, st[3:0]});
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    mk_desc(32'h0000_0040, 1'b0, 1'b0, 1'b0, 11'h008, 11'h008,
            32'h0000_0100, 32'h0000_0120);
    for (int i = 0; i < 4; i++) begin
      mk_desc(32'h0000_0050 + 16 * i, 1'b1, i == 3, i == 3, 11'h008, 11'h008,
              32'h0000_0140 + 32 * i, 32'h0000_0150 + 32 * i);
    end
    repeat (5) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    enable = 1'b1;
    // Host still owns the first descriptor
    wait_own(1'b1);
    chk(mem.words[16], 32'h0000_1234);
    mem.words[16][31] = 1'b1;
    wait_own(1'b0);
    mcast = 1'b1;
    kind = 1'b1;
    src = 2'h1;
    run_frame(32'h0000_0040, 3, 32'hA000_0000, 15'h000C, 1'b0);
    chk(mem.words[64], 32'hA000_0000);
    chk(mem.words[65], 32'hA000_0001);
    chk(mem.words[72], 32'hA000_0002);
    wait_addr(32'h0000_0050);
    $display("test own_and_basic done");
    mk_desc(32'h0000_0040, 1'b1, 1'b0, 1'b1, 11'h004, 11'h008,
            32'h0000_0300, 32'h0000_00A0);
    mk_desc(32'h0000_00A0, 1'b0, 1'b0, 1'b0, 11'h008, 11'h008,
            32'h0000_0380, 32'h0000_0390);
    lat = 4'h3;
    // Each source kind with its own error mix and length edge
    for (int i = 0; i < 4; i++) begin
      src = 2'(i);
      ovf = i == 0;
      crc = i == 1;
      late = i == 2;
      wdog = i == 3;
      drib = i == 1;
      mcast = src[0];
      kind = src[1];
      run_frame(32'h0000_0050 + 16 * i, 1, 32'hB000_0000 + i, lens[i], 1'b0);
    end
    wait_addr(32'h0000_0040);
    $display("test src_and_errors done");
    {ovf, crc, late, wdog, drib, mcast, kind, src} = 9'h000;
    // Frame too big for a single chained buffer
    run_frame(32'h0000_0040, 3, 32'hC000_0000, 15'h0064, 1'b1);
    chk(mem.words[192], 32'hC000_0000);
    chk(mem.words[193], 32'h0000_0000);
    wait_addr(32'h0000_00A0);
    wait_own(1'b1);
    chk(mem.words[40], 32'h0000_1234);
    $display("test truncate_and_chain done");
    test_done();
  end

  // Watchdog
  initial begin
    #100000;
    err_total++;
    test_done();
  end
endmodule // tb
`default_nettype wire
